// ===== logic/rha_agent.sv
// remote host packet agent: decodes request frames, runs accesses, replies
// Behaviour
// - After init serve internal, sideband register, table access; emit interrupt frames.
// - Only frames carrying the reserved EtherType are remote host frames.
// - Frames from the attached host are injected into the ingress pipe.
// - Agent takes frames from egress pipe, matches them, acts on contents.
// - Matching request to this agent is decoded and executed without local processor.
// - After completion build reply to requester MAC, reserved type, into ingress.
// - Reply carries completion status and any returned data.
// - Reserved-type frames addressed to the attached host are passed on to it, cut to the six header words.
// - Request and reply carry a sequence tag pairing them.
`timescale 1ns/1ps
`default_nettype none
`include "rha_defs.svh"
module rha_agent
  import rha_pkg::*;
#(
  parameter logic [15:0] ETHER_TYPE = `RHA_ETYPE_DFLT
) (
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire logic                   initDone,
  input  wire logic [47:0]            agentMac,
  input  wire logic [47:0]            hostMac,
  input  wire logic                   egrValid,
  output logic                        egrReady,
  input  wire logic [`RHA_DATA_W-1:0] egrData,
  input  wire logic                   egrLast,
  output logic                        ingValid,
  input  wire logic                   ingReady,
  output logic [`RHA_DATA_W-1:0]      ingData,
  output logic                        ingLast,
  input  wire logic                   hostRxValid,
  output logic                        hostRxReady,
  input  wire logic [`RHA_DATA_W-1:0] hostRxData,
  input  wire logic                   hostRxLast,
  output logic                        hostTxValid,
  input  wire logic                   hostTxReady,
  output logic [`RHA_DATA_W-1:0]      hostTxData,
  output logic                        hostTxLast,
  output logic                        sbReq,
  output logic                        sbWrite,
  output logic                        sbTable,
  output logic [`RHA_DATA_W-1:0]      sbAddr,
  output logic [`RHA_DATA_W-1:0]      sbWdata,
  input  wire logic                   sbAck,
  input  wire logic [`RHA_DATA_W-1:0] sbRdata,
  input  wire logic                   sbErr,
  input  wire logic [`RHA_INTR_W-1:0] intrIn
);
  rha_agent_st_t st;
  rha_agent_st_t next_st;
  rha_stream_if #(.DW(`RHA_DATA_W)) pushS ();
  rha_stream_if #(.DW(`RHA_DATA_W)) popS ();

  logic [47:0] dstMac;
  logic [47:0] srcMac;
  logic [15:0] etype;
  logic [7:0]  op;
  logic [7:0]  seq;
  logic        egrTake;
  logic        pushReady;

  function automatic logic isSbOp(input logic [7:0] o);
    isSbOp = (o == `RHA_OP_SB_RD) || (o == `RHA_OP_SB_WR) ||
             (o == `RHA_OP_TBL_RD) || (o == `RHA_OP_TBL_WR);
  endfunction : isSbOp

  function automatic rha_word_t buildWord(input logic [2:0] idx, input logic [47:0] d,
                                          input logic [47:0] s, input rha_word_t ctl,
                                          input rha_word_t w4, input rha_word_t w5);
    case (idx)
      `RHA_W_DST_HI:  buildWord = d[47:16];
      `RHA_W_DST_SRC: buildWord = {d[15:0], s[47:32]};
      `RHA_W_SRC_LO:  buildWord = s[31:0];
      `RHA_W_CTL:     buildWord = ctl;
      `RHA_W_ADDR:    buildWord = w4;
      default:        buildWord = w5;
    endcase
  endfunction : buildWord

  assign dstMac  = {st.hdr[`RHA_W_DST_HI], st.hdr[`RHA_W_DST_SRC][31:16]};
  assign srcMac  = {st.hdr[`RHA_W_DST_SRC][15:0], st.hdr[`RHA_W_SRC_LO]};
  assign etype   = st.hdr[`RHA_W_CTL][`RHA_ETYPE_MSB:`RHA_ETYPE_LSB];
  assign op      = st.hdr[`RHA_W_CTL][`RHA_OP_MSB:`RHA_OP_LSB];
  assign seq     = st.hdr[`RHA_W_CTL][`RHA_SEQ_MSB:`RHA_SEQ_LSB];
  assign egrTake = egrValid && egrReady;
  assign pushReady = pushS.ready;

  assign sbReq   = st.sbReq;
  assign sbWrite = (op == `RHA_OP_SB_WR) || (op == `RHA_OP_TBL_WR);
  assign sbTable = (op == `RHA_OP_TBL_RD) || (op == `RHA_OP_TBL_WR);
  assign sbAddr  = st.hdr[`RHA_W_ADDR];
  assign sbWdata = st.hdr[`RHA_W_DATA];

  // before init the pipe is still drained so it never backs up
  assign egrReady = !initDone || (st.state == RHA_IDLE) || (st.state == RHA_RECV) ||
                    (st.state == RHA_DRAIN);

  assign hostTxValid = (st.state == RHA_FWD);
  assign hostTxData  = st.hdr[st.cnt];
  assign hostTxLast  = (st.cnt == `RHA_W_DATA);

  always_comb
  begin
    next_st         = st;
    pushS.valid     = 1'b0;
    pushS.data      = '0;
    pushS.last      = 1'b0;
    hostRxReady     = 1'b0;
    // a new interrupt in the clearing cycle stays pending
    next_st.evtPend = st.evtPend | intrIn;
    case (st.state)
      RHA_IDLE:
      begin
        next_st.cnt = '0;
        if (egrTake && !egrLast)
        begin
          next_st.hdr[0] = egrData;
          next_st.cnt    = 3'h1;
          next_st.state  = RHA_RECV;
        end
        else if (!egrValid && st.evtPend != '0)
        begin
          next_st.rdata   = st.evtPend;
          next_st.evtPend = intrIn;
          next_st.state   = RHA_EVENT;
        end
        else if (!egrValid && hostRxValid)
          next_st.state = RHA_INJECT;
      end
      RHA_RECV, RHA_DRAIN:
      begin
        if (egrTake)
        begin
          if (st.state == RHA_RECV)
          begin
            next_st.hdr[st.cnt] = egrData;
            next_st.cnt         = st.cnt + 1'b1;
            if (st.cnt == `RHA_W_DATA)
              next_st.state = RHA_DRAIN;
          end
          if (egrLast)
          begin
            next_st.cnt   = '0;
            next_st.state = RHA_IDLE;
            // words beyond the header are dropped, short frames are ignored
            if ((st.state == RHA_DRAIN || st.cnt == `RHA_W_DATA) &&
                etype == ETHER_TYPE)
            begin
              if (dstMac == agentMac)
              begin
                next_st.state = RHA_EXEC;
                next_st.sbReq = isSbOp(op);
              end
              else if (dstMac == hostMac)
                next_st.state = RHA_FWD;
            end
          end
        end
      end
      RHA_EXEC:
      begin
        next_st.status = `RHA_ST_OK;
        next_st.rdata  = `RHA_RST_WORD;
        next_st.state  = RHA_REPLY;
        if (isSbOp(op))
        begin
          next_st.state = RHA_EXEC;
          if (st.sbReq && sbAck)
          begin
            next_st.sbReq  = 1'b0;
            // a write returns no data, so the reply carries zero
            next_st.rdata  = sbWrite ? `RHA_RST_WORD : sbRdata;
            next_st.status = sbErr ? `RHA_ST_SB_ERR : `RHA_ST_OK;
            next_st.state  = RHA_REPLY;
          end
        end
        else if (op == `RHA_OP_INT_RD)
          next_st.rdata = st.scratch[sbAddr[1:0]];
        else if (op == `RHA_OP_INT_WR)
          next_st.scratch[sbAddr[1:0]] = sbWdata;
        else
          next_st.status = `RHA_ST_BAD_OP;
      end
      RHA_REPLY, RHA_EVENT:
      begin
        pushS.valid = 1'b1;
        pushS.last  = (st.cnt == `RHA_W_DATA);
        if (st.state == RHA_REPLY)
          pushS.data = buildWord(st.cnt, srcMac, agentMac,
                                 {ETHER_TYPE, op | `RHA_OP_REPLY, seq},
                                 {24'h00_0000, st.status}, st.rdata);
        else
          pushS.data = buildWord(st.cnt, hostMac, agentMac,
                                 {ETHER_TYPE, `RHA_OP_EVENT, st.evtSeq},
                                 st.rdata, `RHA_RST_WORD);
        if (pushS.ready)
        begin
          next_st.cnt = st.cnt + 1'b1;
          if (pushS.last)
          begin
            next_st.cnt   = '0;
            next_st.state = RHA_IDLE;
            if (st.state == RHA_EVENT)
              next_st.evtSeq = st.evtSeq + 1'b1;
          end
        end
      end
      RHA_INJECT:
      begin
        pushS.valid = hostRxValid;
        pushS.data  = hostRxData;
        pushS.last  = hostRxLast;
        hostRxReady = pushS.ready;
        if (hostRxValid && pushS.ready && hostRxLast)
          next_st.state = RHA_IDLE;
      end
      RHA_FWD:
      begin
        if (hostTxReady)
        begin
          next_st.cnt = st.cnt + 1'b1;
          if (st.cnt == `RHA_W_DATA)
          begin
            next_st.cnt   = '0;
            next_st.state = RHA_IDLE;
          end
        end
      end
      default:
        next_st.state = RHA_IDLE;
    endcase
    if (!initDone)
    begin
      next_st.state   = RHA_IDLE;
      next_st.sbReq   = 1'b0;
      next_st.evtPend = '0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      st <= '0;
    else
      st <= next_st;
  end

  // reply, event and injected host frames queue toward the ingress pipe
  rha_fifo #(.WIDTH(`RHA_DATA_W), .DEPTH(`RHA_FIFO_DEPTH)) u_ing_fifo (
    .core_clk (core_clk),
    .reset    (reset),
    .inS      (pushS.snk),
    .outS     (popS.src)
  );

  assign ingValid   = popS.valid;
  assign ingData    = popS.data;
  assign ingLast    = popS.last;
  assign popS.ready = ingReady;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_sb_done;
    st.sbReq && sbAck;
  endsequence
  sequence s_reply_head;
    (st.state == RHA_REPLY) && (st.cnt == '0);
  endsequence

  a_idle_before_init: assert property (!initDone |=> st.state == RHA_IDLE && !sbReq)
    else $error("agent active before init");
  a_sb_req_hold: assert property (sbReq && !sbAck |=> sbReq && $stable(sbAddr))
    else $error("sideband request dropped early");
  a_reply_after_ack: assert property (s_sb_done ##0 initDone |=> s_reply_head)
    else $error("reply not started after ack");
  a_reply_etype: assert property (st.state == RHA_REPLY && st.cnt == `RHA_W_CTL
      |-> pushS.data[31:16] == ETHER_TYPE)
    else $error("reply type wrong");
  a_reply_seq: assert property (st.state == RHA_REPLY && st.cnt == `RHA_W_CTL
      |-> pushS.data[7:0] == seq && pushS.data[15])
    else $error("reply tag wrong");
  a_reply_status: assert property (st.state == RHA_REPLY && st.cnt == `RHA_W_ADDR
      |-> pushS.data[7:0] == st.status)
    else $error("reply status wrong");
  a_ignore_foreign: assert property (initDone && egrTake && egrLast &&
      (st.state == RHA_DRAIN || (st.state == RHA_RECV && st.cnt == `RHA_W_DATA)) &&
      (etype != ETHER_TYPE || (dstMac != agentMac && dstMac != hostMac))
      |=> st.state == RHA_IDLE [*2])
    else $error("foreign frame acted on");
  a_one_op_time: assert property (st.state == RHA_EXEC |-> !egrReady || !initDone)
    else $error("new frame taken during operation");
  a_inject_path: assert property (st.state == RHA_INJECT |-> hostRxReady == pushReady)
    else $error("inject back-pressure broken");
  a_event_start: assert property (initDone && st.state == RHA_IDLE && !egrValid &&
      st.evtPend != '0 ##1 initDone |-> st.state == RHA_EVENT)
    else $error("interrupt frame not started");
  a_fwd_length: assert property (hostTxValid && hostTxLast |-> st.cnt == `RHA_W_DATA)
    else $error("forwarded frame length wrong");
  a_egress_open: assert property (initDone && st.state == RHA_IDLE |-> egrReady)
    else $error("egress not accepted in idle");
endmodule : rha_agent
`default_nettype wire

// ===== logic/rha_defs.svh
// constants of the remote host agent: frame layout, opcodes, status, sizes
`ifndef RHA_DEFS_SVH
`define RHA_DEFS_SVH

`define RHA_DATA_W      32
`define RHA_HDR_WORDS   6
`define RHA_FIFO_DEPTH  4
`define RHA_INTR_W      32
`define RHA_SCRATCH_N   4

// word index of each header field
`define RHA_W_DST_HI    3'h0
`define RHA_W_DST_SRC   3'h1
`define RHA_W_SRC_LO    3'h2
`define RHA_W_CTL       3'h3
`define RHA_W_ADDR      3'h4
`define RHA_W_DATA      3'h5

// control word field positions
`define RHA_ETYPE_MSB   31
`define RHA_ETYPE_LSB   16
`define RHA_OP_MSB      15
`define RHA_OP_LSB      8
`define RHA_SEQ_MSB     7
`define RHA_SEQ_LSB     0

`define RHA_OP_INT_RD   8'h01
`define RHA_OP_INT_WR   8'h02
`define RHA_OP_SB_RD    8'h03
`define RHA_OP_SB_WR    8'h04
`define RHA_OP_TBL_RD   8'h05
`define RHA_OP_TBL_WR   8'h06
`define RHA_OP_EVENT    8'h10
`define RHA_OP_REPLY    8'h80

`define RHA_ST_OK       8'h00
`define RHA_ST_SB_ERR   8'h01
`define RHA_ST_BAD_OP   8'h02

`define RHA_RST_WORD    32'h0000_0000
`define RHA_ETYPE_DFLT  16'h9000

`endif

// ===== logic/rha_fifo.sv
// small word FIFO with last flag, valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module rha_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 4
) (
  input wire logic   core_clk,
  input wire logic   reset,
  rha_stream_if.snk  inS,
  rha_stream_if.src  outS
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH:0] mem;
    logic [AW-1:0]             wp;
    logic [AW-1:0]             rp;
    logic [CW-1:0]             cnt;
  } rha_fifo_st_t;

  rha_fifo_st_t st;
  rha_fifo_st_t next_st;
  logic         push;
  logic         pop;

  // wrap explicitly so depths that are not a power of two work
  function automatic logic [AW-1:0] nextPtr(input logic [AW-1:0] p);
    nextPtr = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : nextPtr

  assign inS.ready  = (st.cnt != CW'(DEPTH));
  assign outS.valid = (st.cnt != '0);
  assign outS.data  = st.mem[st.rp][WIDTH-1:0];
  assign outS.last  = st.mem[st.rp][WIDTH];
  assign push       = inS.valid && inS.ready;
  assign pop        = outS.valid && outS.ready;

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.mem[st.wp] = {inS.last, inS.data};
      next_st.wp         = nextPtr(st.wp);
    end
    if (pop)
      next_st.rp = nextPtr(st.rp);
    if (push && !pop)
      next_st.cnt = st.cnt + 1'b1;
    else if (pop && !push)
      next_st.cnt = st.cnt - 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (reset)
      st <= '0;
    else
      st <= next_st;
  end
endmodule : rha_fifo
`default_nettype wire

// ===== logic/rha_pkg.sv
// types shared by the remote host agent modules
`default_nettype none
package rha_pkg;
`include "rha_defs.svh"

  typedef enum logic [2:0] {
    RHA_IDLE   = 3'h0,
    RHA_RECV   = 3'h1,
    RHA_EXEC   = 3'h3,
    RHA_REPLY  = 3'h2,
    RHA_DRAIN  = 3'h6,
    RHA_INJECT = 3'h7,
    RHA_FWD    = 3'h5,
    RHA_EVENT  = 3'h4
  } rha_state_t;

  typedef logic [`RHA_DATA_W-1:0] rha_word_t;

  typedef struct packed {
    rha_state_t                               state;
    logic [2:0]                               cnt;
    logic [`RHA_HDR_WORDS-1:0][`RHA_DATA_W-1:0] hdr;
    logic [7:0]                               status;
    rha_word_t                                rdata;
    logic                                     sbReq;
    logic [`RHA_INTR_W-1:0]                   evtPend;
    logic [7:0]                               evtSeq;
    logic [`RHA_SCRATCH_N-1:0][`RHA_DATA_W-1:0] scratch;
  } rha_agent_st_t;

endpackage : rha_pkg
`default_nettype wire

// ===== logic/rha_stream_if.sv
// word stream with valid, ready and last between agent modules
`timescale 1ns/1ps
`default_nettype none
interface rha_stream_if #(parameter int DW = 32);
  logic          valid;
  logic          ready;
  logic [DW-1:0] data;
  logic          last;
  modport src (output valid, output data, output last, input ready);
  modport snk (input valid, input data, input last, output ready);
endinterface : rha_stream_if
`default_nettype wire

// ===== tb/rha_agent_tb.sv
// self-checking bench for the remote host packet agent
`timescale 1ns/1ps
`default_nettype none
`include "rha_defs.svh"
module rha_agent_tb
  import rha_pkg::*;
;
  localparam logic [47:0] AGENT = 48'h0200_0000_0A01;
  localparam logic [47:0] HOST  = 48'h0200_0000_0B02;
  localparam logic [47:0] REM   = 48'h0200_0000_0C03;
  localparam logic [15:0] ET    = 16'h9000;
  typedef rha_word_t rha_frm_t [6];
  logic      core_clk = 1'b0;
  logic      reset = 1'b1;
  logic      initDone = 1'b0;
  logic      egrValid = 1'b0, egrLast = 1'b0, ingReady = 1'b0;
  logic      hostRxValid = 1'b0, hostRxLast = 1'b0, hostTxReady = 1'b0;
  rha_word_t egrData = 32'h0, hostRxData = 32'h0, intrIn = 32'h0;
  logic      egrReady, ingValid, ingLast, hostRxReady, hostTxValid, hostTxLast;
  rha_word_t ingData, hostTxData, sbAddr, sbWdata, sbRdata, ackW, capA, capD;
  logic      sbReq, sbWrite, sbTable, sbErr, capW, capT;
  logic [3:0] latency = 4'h0;
  int        errors = 0, n_compared = 0, cycles = 0;

  rha_agent #(.ETHER_TYPE(ET)) u_dut (
    .core_clk(core_clk), .reset(reset), .initDone(initDone), .agentMac(AGENT),
    .hostMac(HOST), .egrValid(egrValid), .egrReady(egrReady), .egrData(egrData),
    .egrLast(egrLast), .ingValid(ingValid), .ingReady(ingReady), .ingData(ingData),
    .ingLast(ingLast), .hostRxValid(hostRxValid), .hostRxReady(hostRxReady),
    .hostRxData(hostRxData), .hostRxLast(hostRxLast), .hostTxValid(hostTxValid),
    .hostTxReady(hostTxReady), .hostTxData(hostTxData), .hostTxLast(hostTxLast),
    .sbReq(sbReq), .sbWrite(sbWrite), .sbTable(sbTable), .sbAddr(sbAddr),
    .sbWdata(sbWdata), .sbAck(ackW[0]), .sbRdata(sbRdata), .sbErr(sbErr), .intrIn(intrIn)
  );
  rha_sb_model u_sb (
    .core_clk(core_clk), .reset(reset), .latency(latency), .sbReq(sbReq),
    .sbAddr(sbAddr), .sbAck(ackW), .sbRdata(sbRdata), .sbErr(sbErr)
  );

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    if (sbReq && ackW[0])
    begin
      capW <= sbWrite;
      capT <= sbTable;
      capA <= sbAddr;
      capD <= sbWdata;
    end
    if (cycles == 20000)
    begin
      errors++;
      $display("Error at %0t: timeout", $time);
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic chk(input rha_word_t got, input rha_word_t exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic rha_frm_t mk(input logic [47:0] d, input logic [47:0] s,
    input logic [15:0] et, input logic [7:0] op, input logic [7:0] seq,
    input rha_word_t a, input rha_word_t w);
    rha_frm_t f;
    f[0] = d[47:16];
    f[1] = {d[15:0], s[47:32]};
    f[2] = s[31:0];
    f[3] = {et, op, seq};
    f[4] = a;
    f[5] = w;
    return f;
  endfunction : mk

  task automatic send(input logic host, input rha_frm_t f);
    int k;
    for (int i = 0; i < 6; i++)
    begin
      if (host)
      begin
        hostRxValid = 1'b1;
        hostRxData = f[i];
        hostRxLast = (i == 5);
      end
      else
      begin
        egrValid = 1'b1;
        egrData = f[i];
        egrLast = (i == 5);
      end
      k = 0;
      @(posedge core_clk);
      while (!(host ? hostRxReady : egrReady) && k < 300)
      begin
        k++;
        @(posedge core_clk);
      end
      chk(32'(k >= 300), 32'h0);
      #1;
    end
    egrValid = 1'b0;
    egrLast = 1'b0;
    hostRxValid = 1'b0;
    hostRxLast = 1'b0;
    egrData = ~egrData;
    hostRxData = ~hostRxData;
  endtask : send

  task automatic recv(input logic host, input rha_frm_t e, input int stall);
    int k;
    k = 0;
    repeat (stall) @(posedge core_clk);
    #1;
    if (host)
      hostTxReady = 1'b1;
    else
      ingReady = 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      @(posedge core_clk);
      while (!(host ? hostTxValid : ingValid) && k < 300)
      begin
        k++;
        @(posedge core_clk);
      end
      chk(host ? hostTxData : ingData, e[i]);
      chk(host ? hostTxLast : ingLast, i == 5);
    end
    chk(32'(k >= 300), 32'h0);
    #1;
    hostTxReady = 1'b0;
    ingReady = 1'b0;
  endtask : recv

  task automatic quiet(input int n);
    logic seen;
    seen = 1'b0;
    repeat (n)
    begin
      @(posedge core_clk);
      seen = seen | ingValid | hostTxValid;
    end
    #1;
    chk(seen, 1'b0);
  endtask : quiet

  task automatic t_init();
    send(0, mk(AGENT, REM, ET, `RHA_OP_INT_RD, 8'h01, 32'h0, 32'h0));
    quiet(40);
  endtask : t_init

  task automatic t_internal();
    send(0, mk(AGENT, REM, ET, `RHA_OP_INT_WR, 8'h11, 32'h3, 32'hCAFE_0042));
    chk(egrReady, 1'b0);
    chk(hostRxReady, 1'b0);
    recv(0, mk(REM, AGENT, ET, 8'h82, 8'h11, 32'h0, 32'h0), 0);
    send(0, mk(AGENT, REM, ET, `RHA_OP_INT_RD, 8'h12, 32'h3, 32'h0));
    recv(0, mk(REM, AGENT, ET, 8'h81, 8'h12, 32'h0, 32'hCAFE_0042), 3);
    send(0, mk(AGENT, REM, ET, `RHA_OP_INT_RD, 8'h13, 32'h1, 32'h0));
    recv(0, mk(REM, AGENT, ET, 8'h81, 8'h13, 32'h0, 32'h0), 0);
  endtask : t_internal

  task automatic t_order();
    fork
      begin
        send(0, mk(AGENT, REM, ET, `RHA_OP_INT_WR, 8'h21, 32'h0, 32'h0000_5A5A));
        @(posedge core_clk);
        #1;
        send(0, mk(AGENT, REM, ET, `RHA_OP_INT_RD, 8'h22, 32'h0, 32'h0));
      end
      begin
        recv(0, mk(REM, AGENT, ET, 8'h82, 8'h21, 32'h0, 32'h0), 6);
        recv(0, mk(REM, AGENT, ET, 8'h81, 8'h22, 32'h0, 32'h0000_5A5A), 0);
      end
    join
    quiet(5);
  endtask : t_order

  task automatic t_sideband();
    rha_word_t a;
    rha_word_t d;
    for (int op = 3; op <= 6; op++)
    begin
      latency = 4'((op - 3) * 4);
      a = 32'h0000_0100 + op;
      d = 32'hD000_0000 + op;
      send(0, mk(AGENT, REM, ET, op[7:0], op[7:0], a, d));
      recv(0, mk(REM, AGENT, ET, op[7:0] | 8'h80, op[7:0], 32'h0,
        op[0] ? (a ^ 32'hA5A5_0000) : 32'h0), 2);
      chk(capA, a);
      chk(capW, !op[0]);
      chk(capT, op >= 5);
      if (!op[0])
        chk(capD, d);
    end
    send(0, mk(AGENT, REM, ET, `RHA_OP_SB_RD, 8'h31, 32'h0000_0EEE, 32'h0));
    recv(0, mk(REM, AGENT, ET, 8'h83, 8'h31, 32'h1, 32'h0), 0);
    send(0, mk(AGENT, REM, ET, 8'h07, 8'h32, 32'h0, 32'h0));
    recv(0, mk(REM, AGENT, ET, 8'h87, 8'h32, 32'h2, 32'h0), 0);
  endtask : t_sideband

  task automatic t_drop();
    send(0, mk(AGENT, REM, ET ^ 16'h0001, `RHA_OP_INT_RD, 8'h41, 32'h0, 32'h0));
    quiet(30);
    send(0, mk(REM, HOST, ET, `RHA_OP_INT_RD, 8'h42, 32'h0, 32'h0));
    quiet(30);
  endtask : t_drop

  task automatic t_paths();
    rha_frm_t f;
    f = mk(REM, HOST, ET, `RHA_OP_SB_RD, 8'h51, 32'h0000_0777, 32'h1234_5678);
    fork
      send(1, f);
      recv(0, f, 5);
    join
    f = mk(HOST, REM, ET, 8'h83, 8'h52, 32'h0, 32'h8765_4321);
    send(0, f);
    recv(1, f, 4);
    quiet(5);
  endtask : t_paths

  task automatic t_event();
    intrIn = 32'h0000_0010;
    @(posedge core_clk);
    #1;
    intrIn = 32'h0;
    recv(0, mk(HOST, AGENT, ET, `RHA_OP_EVENT, 8'h00, 32'h0000_0010, 32'h0), 2);
    intrIn = 32'h8000_0001;
    @(posedge core_clk);
    #1;
    intrIn = 32'h0;
    recv(0, mk(HOST, AGENT, ET, `RHA_OP_EVENT, 8'h01, 32'h8000_0001, 32'h0), 0);
    quiet(10);
  endtask : t_event

  initial
  begin
    repeat (10) @(posedge core_clk);
    #1;
    reset = 1'b0;
    t_init();
    initDone = 1'b1;
    t_internal();
    t_order();
    t_sideband();
    t_drop();
    t_paths();
    t_event();
    report_and_stop();
  end
endmodule : rha_agent_tb
`default_nettype wire

// ===== tb/rha_sb_model.sv
// sideband responder standing in for the register and table fabric
`timescale 1ns/1ps
`default_nettype none
module rha_sb_model
  import rha_pkg::*;
#(
  parameter logic [31:0] ERR_ADDR = 32'h0000_0EEE
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic [3:0]  latency,
  input  wire logic        sbReq,
  input  wire logic [31:0] sbAddr,
  output rha_word_t        sbAck,
  output rha_word_t        sbRdata,
  output logic             sbErr
);
  logic [3:0] cnt;
  logic       done;
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      cnt <= 4'h0;
      done <= 1'b0;
      sbAck <= 32'h0;
      sbErr <= 1'b0;
      sbRdata <= 32'h0;
    end
    else
    begin
      sbAck <= 32'h0;
      sbErr <= 1'b0;
      // read data is inverted every cycle outside the ack cycle, so it is not held
      sbRdata <= ~sbRdata;
      if (!sbReq)
        done <= 1'b0;
      if (sbReq && !done)
      begin
        if (cnt == latency)
        begin
          sbAck <= 32'h1;
          done <= 1'b1;
          cnt <= 4'h0;
          sbErr <= (sbAddr == ERR_ADDR);
          sbRdata <= (sbAddr == ERR_ADDR) ? 32'h0 : (sbAddr ^ 32'hA5A5_0000);
        end
        else
          cnt <= cnt + 4'h1;
      end
    end
  end
endmodule : rha_sb_model
`default_nettype wire
